// ===== psio_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the protection status I/O pins.
// Assumes: APB byte addresses, 32-bit data, 100 MHz pclk.
// Notes: Definitions only.
`ifndef PSIO_MAP_SVH
`define PSIO_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PSIO_OFS_CFG0 12'h000
`define PSIO_OFS_CFG1 12'h004
`define PSIO_OFS_CFG2 12'h008
`define PSIO_OFS_PER0 12'h00c
`define PSIO_OFS_PER1 12'h010
`define PSIO_OFS_PER2 12'h014
`define PSIO_OFS_DUTY0 12'h018
`define PSIO_OFS_DUTY1 12'h01c
`define PSIO_OFS_DUTY2 12'h020
`define PSIO_OFS_STATUS 12'h024
`define PSIO_OFS_IRQ_STAT 12'h028
`define PSIO_OFS_IRQ_MASK 12'h02c

// ----------------------------------------------------------------
// Fields and encodings
// ----------------------------------------------------------------
`define PSIO_CFG_ROLE_LSB 0
`define PSIO_CFG_INV_BIT 2
`define PSIO_CFG_VAL_BIT 3
`define PSIO_CFG_PWM_BIT 4
`define PSIO_ROLE_DEFAULT 2'h0
`define PSIO_ROLE_INPUT 2'h1
`define PSIO_ROLE_OUTPUT 2'h2
`define PSIO_IRQ_RX_BIT 0
`define PSIO_IRQ_TX_BIT 1
`define PSIO_IDX_NONE 4'hf

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PSIO_CFG_RST 5'h00
`define PSIO_PER_RST 16'h03e8
`define PSIO_DUTY_RST 16'h01f4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PSIO_CLK_PERIOD_NS 10
`define PSIO_PULSE_LOW_US 30
`define PSIO_PULSE_CYC (((`PSIO_PULSE_LOW_US * 1000) + `PSIO_CLK_PERIOD_NS - 1) / `PSIO_CLK_PERIOD_NS)

`endif

// ===== psio_pkg.sv
// Purpose: Types of the protection status I/O pins.
// Assumes: Constants come from psio_map.svh.
// Notes: Whole module state is one packed struct.
`default_nettype none
package psio_pkg;

	typedef enum logic [0:0] {TX_IDLE, TX_LOW} psio_tx_type;

	typedef struct packed {
		logic [2:0][2:0] sync;
		logic [2:0] filt;
		logic armed;
		logic [11:0] low_cnt;
		psio_tx_type tx;
		logic [11:0] tx_cnt;
		logic on_prev;
		logic [2:0][4:0] cfg;
		logic [2:0][15:0] per;
		logic [2:0][15:0] duty;
		logic [2:0][15:0] pwm_cnt;
		logic [1:0] irq_stat;
		logic [1:0] irq_mask;
		logic [2:0] pin_o;
		logic [2:0] pin_oe;
		logic irq;
		logic clear;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} psio_state_type;

endpackage
`default_nettype wire

// ===== psio_top.sv
// Purpose: Logic behind three configurable digital I/O pins with protection clear, protection state and off status.
// Assumes: APB slave on pclk; protect_active and output_on come from logic on pclk.
// Notes: Pins are three signals each; the bench resolves the wire.
//
// Functional notes
// - Each pin: default, input or output role.
// - Output value 0 drives high, 1 low.
// - Output role may emit PWM from period, duty.
// - Input role samples and reports pin level.
// - Per-pin invert flips input and output levels.
// - Valid pulse on pin one clears protection.
// - Pin one pulses when output turns on unprotected.
// - Pulses stay low at least 30 us.
// - Pin two high unprotected, low in protection.
// - Pin three high when output off, low on.
// - Pulses are falling edges from idle high.
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "psio_map.svh"

module psio_top
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0] pin_i,
	output logic [2:0] pin_o,
	output logic [2:0] pin_oe,
	input wire logic protect_active,
	input wire logic output_on,
	output logic protect_clear,
	output logic irq
);

	localparam logic [11:0] PULSE_LAST = 12'(`PSIO_PULSE_CYC - 1);

	psio_pkg::psio_state_type q;
	psio_pkg::psio_state_type d;
	logic rx_fire;
	logic tx_start;
	logic [3:0] idx;
	logic [1:0] w1c;

	// ----------------------------------------------------------------
	// Decoding
	// ----------------------------------------------------------------
	function automatic logic [3:0] reg_index(input logic [11:0] a);
		case (a)
			`PSIO_OFS_CFG0: return 4'h0;
			`PSIO_OFS_CFG1: return 4'h1;
			`PSIO_OFS_CFG2: return 4'h2;
			`PSIO_OFS_PER0: return 4'h3;
			`PSIO_OFS_PER1: return 4'h4;
			`PSIO_OFS_PER2: return 4'h5;
			`PSIO_OFS_DUTY0: return 4'h6;
			`PSIO_OFS_DUTY1: return 4'h7;
			`PSIO_OFS_DUTY2: return 4'h8;
			`PSIO_OFS_STATUS: return 4'h9;
			`PSIO_OFS_IRQ_STAT: return 4'ha;
			`PSIO_OFS_IRQ_MASK: return 4'hb;
			default: return `PSIO_IDX_NONE;
		endcase
	endfunction

	function automatic logic [1:0] role_of(input logic [4:0] c);
		return c[`PSIO_CFG_ROLE_LSB +: 2];
	endfunction

	// Asserted pulse level: low pin under normal polarity, high pin under invert.
	function automatic logic pulse_active(input logic lvl, input logic [4:0] c);
		return ~(lvl ^ c[`PSIO_CFG_INV_BIT]);
	endfunction

	assign idx = reg_index(paddr);
	assign rx_fire = (role_of(q.cfg[0]) == `PSIO_ROLE_DEFAULT) && (q.tx == psio_pkg::TX_IDLE) &&
		pulse_active(q.filt[0], q.cfg[0]) && q.armed && (q.low_cnt == PULSE_LAST);
	assign tx_start = (role_of(q.cfg[0]) == `PSIO_ROLE_DEFAULT) && (q.tx == psio_pkg::TX_IDLE) &&
		output_on && !q.on_prev && !protect_active;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		d = q;
		w1c = 2'h0;
		d.clear = 1'b0;
		d.on_prev = output_on;
		for (int i = 0; i < 3; i++)
		begin
			// A level counts once the second and third stages agree.
			d.sync[i] = {q.sync[i][1:0], pin_i[i]};
			if (q.sync[i][1] == q.sync[i][2])
			begin
				d.filt[i] = q.sync[i][2];
			end
			if ({1'b0, q.pwm_cnt[i]} + 17'h1 >= {1'b0, q.per[i]})
			begin
				d.pwm_cnt[i] = 16'h0;
			end
			else
			begin
				d.pwm_cnt[i] = q.pwm_cnt[i] + 16'h1;
			end
		end

		// Pulse receiver on pin one; own pulses are not heard back.
		if (role_of(q.cfg[0]) == `PSIO_ROLE_DEFAULT && q.tx == psio_pkg::TX_IDLE)
		begin
			if (pulse_active(q.filt[0], q.cfg[0]))
			begin
				if (q.low_cnt != PULSE_LAST)
				begin
					d.low_cnt = q.low_cnt + 12'h1;
				end
				else if (q.armed)
				begin
					d.armed = 1'b0;
				end
			end
			else
			begin
				d.low_cnt = 12'h0;
				d.armed = 1'b1;
			end
		end
		else
		begin
			d.low_cnt = 12'h0;
			d.armed = 1'b0;
		end
		if (rx_fire && protect_active)
		begin
			d.clear = 1'b1;
		end

		// Pulse transmitter on pin one.
		case (q.tx)
			psio_pkg::TX_IDLE:
			begin
				if (tx_start)
				begin
					d.tx = psio_pkg::TX_LOW;
					d.tx_cnt = 12'h0;
				end
			end
			psio_pkg::TX_LOW:
			begin
				if (q.tx_cnt == PULSE_LAST)
				begin
					d.tx = psio_pkg::TX_IDLE;
				end
				else
				begin
					d.tx_cnt = q.tx_cnt + 12'h1;
				end
			end
			default:
			begin
				d.tx = psio_pkg::TX_IDLE;
			end
		endcase

		// APB: setup cycle loads the answer, access cycle completes it.
		if (psel && !penable)
		begin
			d.pready = 1'b1;
			d.pslverr = (idx == `PSIO_IDX_NONE);
			case (idx)
				4'h0, 4'h1, 4'h2: d.prdata = {27'h0, q.cfg[idx[1:0]]};
				4'h3, 4'h4, 4'h5: d.prdata = {16'h0, q.per[2'(idx - 4'h3)]};
				4'h6, 4'h7, 4'h8: d.prdata = {16'h0, q.duty[2'(idx - 4'h6)]};
				4'h9: d.prdata = {27'h0, q.filt ^ {q.cfg[2][`PSIO_CFG_INV_BIT], q.cfg[1][`PSIO_CFG_INV_BIT],
					q.cfg[0][`PSIO_CFG_INV_BIT]}, output_on, protect_active};
				4'ha: d.prdata = {30'h0, q.irq_stat};
				4'hb: d.prdata = {30'h0, q.irq_mask};
				default: d.prdata = 32'h0;
			endcase
		end
		else if (psel && penable && q.pready)
		begin
			d.pready = 1'b0;
			d.pslverr = 1'b0;
			if (pwrite)
			begin
				case (idx)
					4'h0, 4'h1, 4'h2: d.cfg[idx[1:0]] = pwdata[4:0];
					4'h3, 4'h4, 4'h5: d.per[2'(idx - 4'h3)] = pwdata[15:0];
					4'h6, 4'h7, 4'h8: d.duty[2'(idx - 4'h6)] = pwdata[15:0];
					4'ha: w1c = pwdata[1:0];
					4'hb: d.irq_mask = pwdata[1:0];
					default: d.irq_mask = q.irq_mask;
				endcase
			end
		end

		// Set wins over a write-one clear in the same cycle.
		d.irq_stat = (q.irq_stat & ~w1c);
		d.irq_stat[`PSIO_IRQ_RX_BIT] = d.irq_stat[`PSIO_IRQ_RX_BIT] | rx_fire;
		d.irq_stat[`PSIO_IRQ_TX_BIT] = d.irq_stat[`PSIO_IRQ_TX_BIT] | tx_start;
		d.irq = |(d.irq_stat & d.irq_mask);

		// Pin drivers.
		for (int i = 0; i < 3; i++)
		begin
			case (role_of(d.cfg[i]))
				`PSIO_ROLE_DEFAULT:
				begin
					if (i == 0)
					begin
						d.pin_oe[i] = (d.tx == psio_pkg::TX_LOW);
						d.pin_o[i] = d.cfg[i][`PSIO_CFG_INV_BIT];
					end
					else if (i == 1)
					begin
						d.pin_oe[i] = 1'b1;
						d.pin_o[i] = ~protect_active ^ d.cfg[i][`PSIO_CFG_INV_BIT];
					end
					else
					begin
						d.pin_oe[i] = 1'b1;
						d.pin_o[i] = ~output_on ^ d.cfg[i][`PSIO_CFG_INV_BIT];
					end
				end
				`PSIO_ROLE_OUTPUT:
				begin
					d.pin_oe[i] = 1'b1;
					if (d.cfg[i][`PSIO_CFG_PWM_BIT])
					begin
						d.pin_o[i] = (d.pwm_cnt[i] < d.duty[i]) ^ d.cfg[i][`PSIO_CFG_INV_BIT];
					end
					else
					begin
						d.pin_o[i] = ~(d.cfg[i][`PSIO_CFG_VAL_BIT] ^ d.cfg[i][`PSIO_CFG_INV_BIT]);
					end
				end
				default:
				begin
					d.pin_oe[i] = 1'b0;
					d.pin_o[i] = 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			q <= '0;
			q.sync <= '1;
			q.filt <= 3'h7;
			q.cfg <= {3{`PSIO_CFG_RST}};
			q.per <= {3{`PSIO_PER_RST}};
			q.duty <= {3{`PSIO_DUTY_RST}};
			q.tx <= psio_pkg::TX_IDLE;
		end
		else
		begin
			q <= d;
		end
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign pin_o = q.pin_o;
	assign pin_oe = q.pin_oe;
	assign protect_clear = q.clear;
	assign irq = q.irq;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_input_released;
		@(posedge pclk) disable iff (!presetn)
		role_of(d.cfg[2]) == `PSIO_ROLE_INPUT |=> !pin_oe[2];
	endproperty
	a_input_released: assert property (p_input_released) else $error("input pin driven");

	property p_out_level;
		@(posedge pclk) disable iff (!presetn)
		role_of(q.cfg[1]) == `PSIO_ROLE_OUTPUT && !q.cfg[1][`PSIO_CFG_PWM_BIT] ##1 $stable(q.cfg[1])
		|-> pin_oe[1] && pin_o[1] == !(q.cfg[1][`PSIO_CFG_VAL_BIT] ^ q.cfg[1][`PSIO_CFG_INV_BIT]);
	endproperty
	a_out_level: assert property (p_out_level) else $error("output level wrong");

	property p_pwm_wrap;
		@(posedge pclk) disable iff (!presetn)
		q.per[2] > 16'h1 && q.pwm_cnt[2] == q.per[2] - 16'h1 |=> q.pwm_cnt[2] == 16'h0;
	endproperty
	a_pwm_wrap: assert property (p_pwm_wrap) else $error("pwm period wrong");

	property p_prot_level;
		@(posedge pclk) disable iff (!presetn)
		$past(presetn) && role_of(q.cfg[1]) == `PSIO_ROLE_DEFAULT && $stable(q.cfg[1]) && $stable(protect_active)
		|-> pin_o[1] == ($past(!protect_active) ^ q.cfg[1][`PSIO_CFG_INV_BIT]);
	endproperty
	a_prot_level: assert property (p_prot_level) else $error("protection level wrong");

	property p_off_level;
		@(posedge pclk) disable iff (!presetn)
		$past(presetn) && role_of(q.cfg[2]) == `PSIO_ROLE_DEFAULT && $stable(q.cfg[2]) && $stable(output_on)
		|-> pin_oe[2] && pin_o[2] == ($past(!output_on) ^ q.cfg[2][`PSIO_CFG_INV_BIT]);
	endproperty
	a_off_level: assert property (p_off_level) else $error("off status level wrong");

	property p_clear_pulse;
		@(posedge pclk) disable iff (!presetn)
		rx_fire && protect_active |=> protect_clear ##1 !protect_clear;
	endproperty
	a_clear_pulse: assert property (p_clear_pulse) else $error("clear pulse missing");

	property p_rx_width;
		@(posedge pclk) disable iff (!presetn)
		rx_fire |-> q.low_cnt == PULSE_LAST && pulse_active(q.filt[0], q.cfg[0]);
	endproperty
	a_rx_width: assert property (p_rx_width) else $error("short pulse accepted");

	property p_tx_start;
		@(posedge pclk) disable iff (!presetn)
		tx_start |=> q.tx == psio_pkg::TX_LOW && q.tx_cnt == 12'h0;
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("pulse not started");

	property p_tx_width;
		@(posedge pclk) disable iff (!presetn)
		$fell(pin_oe[0]) && $past(q.tx) == psio_pkg::TX_LOW && role_of(q.cfg[0]) == `PSIO_ROLE_DEFAULT
		|-> $past(q.tx_cnt) == PULSE_LAST;
	endproperty
	a_tx_width: assert property (p_tx_width) else $error("sent pulse too short");

	property p_sync;
		@(posedge pclk) disable iff (!presetn)
		$changed(q.filt[0]) |-> $past(q.sync[0][1]) == $past(q.sync[0][2]);
	endproperty
	a_sync: assert property (p_sync) else $error("unsynchronised input used");

endmodule
`default_nettype wire

// ===== psio_far.sv
// Purpose: Outside equipment on the three pins: pull-ups, optional drive, pulse meter on pin one.
// Assumes: A released line with no outside drive sits at the pull-up level.
// Notes: Outside pulses pull the line low from idle high and then release it.
`timescale 1ns/10ps
`default_nettype none

module psio_far
(
	input wire logic pclk,
	input wire logic [2:0] pin_o,
	input wire logic [2:0] pin_oe,
	input wire logic [2:0] ext_en,
	input wire logic [2:0] ext_lvl,
	output logic [2:0] pin_i,
	output logic [15:0] low_len,
	output logic [7:0] falls
);
	logic [15:0] cnt = 16'h0000;
	logic prev = 1'b1;

	always_comb
		for (int i = 0; i < 3; i++)
			pin_i[i] = pin_oe[i] ? pin_o[i] : (ext_en[i] ? ext_lvl[i] : 1'b1);

	// Measures the low time of every pulse seen on pin one.
	initial
	begin
		low_len = 16'h0000;
		falls = 8'h00;
	end
	always @(posedge pclk)
	begin
		if (prev && !pin_i[0])
			falls <= falls + 8'h01;
		cnt <= pin_i[0] ? 16'h0000 : cnt + 16'h0001;
		if (!prev && pin_i[0])
			low_len <= cnt;
		prev <= pin_i[0];
	end
endmodule
`default_nettype wire

// ===== tb_protection_status_io_pins.sv
// Purpose: Self-checking bench of the protection status I/O pins.
// Assumes: Zero-wait APB slave; one-cycle protect_clear pulse.
// Notes: Pin levels are resolved by the outside equipment model.
`timescale 1ns/10ps
`default_nettype none
`include "psio_map.svh"

module tb_protection_status_io_pins;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [2:0] pin_i;
	logic [2:0] pin_o;
	logic [2:0] pin_oe;
	logic protect_active = 1'b0;
	logic output_on = 1'b0;
	logic protect_clear;
	logic irq;
	logic [2:0] ext_en = 3'h0;
	logic [2:0] ext_lvl = 3'h7;
	logic [15:0] low_len;
	logic [7:0] falls;
	logic [31:0] q;
	logic err;
	int num_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	int clr_cnt = 0;

	psio_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .protect_active(protect_active),
		.output_on(output_on), .protect_clear(protect_clear), .irq(irq));
	psio_far i_far (.pclk(pclk), .pin_o(pin_o), .pin_oe(pin_oe), .ext_en(ext_en), .ext_lvl(ext_lvl),
		.pin_i(pin_i), .low_len(low_len), .falls(falls));

	always #5 pclk = ~pclk;

	always @(posedge pclk)
	begin
		cyc++;
		if (protect_clear === 1'b1)
			clr_cnt++;
		if (cyc == 40000)
		begin
			num_errors++;
			end_sim();
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic pull_low(input int n);
		ext_en[0] <= 1'b1;
		ext_lvl[0] <= 1'b0;
		wait_cyc(n);
		ext_en[0] <= 1'b0;
		wait_cyc(10);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_levels();
		// Pin one listens here so that output_on edges do not start a pulse.
		apb(1'b1, `PSIO_OFS_CFG0, 32'h1);
		for (int k = 0; k < 8; k++)
		begin
			if (k == 4)
				apb(1'b1, `PSIO_OFS_CFG1, 32'h4);
			if (k == 4)
				apb(1'b1, `PSIO_OFS_CFG2, 32'h4);
			protect_active <= k[0];
			output_on <= k[1];
			wait_cyc(3);
			chk(pin_oe[2:1], 2'b11);
			chk(pin_o[1], !k[0] ^ k[2]);
			chk(pin_o[2], !k[1] ^ k[2]);
		end
		apb(1'b1, `PSIO_OFS_CFG1, 32'h0);
		apb(1'b1, `PSIO_OFS_CFG2, 32'h0);
	endtask

	task automatic t_gpo();
		for (int v = 0; v < 4; v++)
		begin
			apb(1'b1, `PSIO_OFS_CFG0, 32'h2 | (v[0] << 3) | (v[1] << 2));
			apb(1'b1, `PSIO_OFS_CFG1, 32'h2 | (v[0] << 3) | (v[1] << 2));
			wait_cyc(2);
			chk({pin_oe[0], pin_o[0]}, {1'b1, !(v[0] ^ v[1])});
			chk({pin_oe[1], pin_o[1]}, {1'b1, !(v[0] ^ v[1])});
		end
		apb(1'b1, `PSIO_OFS_CFG1, 32'h0);
	endtask

	task automatic t_pwm();
		int h;
		apb(1'b1, `PSIO_OFS_PER0, 32'd10);
		apb(1'b1, `PSIO_OFS_DUTY0, 32'd3);
		for (int v = 0; v < 2; v++)
		begin
			apb(1'b1, `PSIO_OFS_CFG0, 32'h12 | (v << 2));
			wait_cyc(5);
			h = 0;
			repeat (20) @(posedge pclk) h += pin_o[0];
			chk(h, v ? 14 : 6);
		end
		apb(1'b1, `PSIO_OFS_CFG0, 32'h0);
	endtask

	task automatic t_gpi();
		apb(1'b1, `PSIO_OFS_CFG2, 32'h1);
		ext_en[2] <= 1'b1;
		for (int v = 0; v < 3; v++)
		begin
			if (v == 2)
				apb(1'b1, `PSIO_OFS_CFG2, 32'h5);
			ext_lvl[2] <= v[0];
			wait_cyc(8);
			chk(pin_oe[2], 1'b0);
			apb(1'b0, `PSIO_OFS_STATUS, 32'h0);
			chk(q[4], v[0] ^ (v == 2));
		end
		apb(1'b1, `PSIO_OFS_CFG2, 32'h0);
		ext_en[2] <= 1'b0;
	endtask

	task automatic t_clear();
		apb(1'b1, `PSIO_OFS_IRQ_MASK, 32'h1);
		apb(1'b1, `PSIO_OFS_IRQ_STAT, 32'h3);
		protect_active <= 1'b1;
		clr_cnt = 0;
		pull_low(2000);
		chk(clr_cnt, 0);
		chk(irq, 1'b0);
		pull_low(3100);
		chk(clr_cnt, 1);
		chk(irq, 1'b1);
		apb(1'b1, `PSIO_OFS_IRQ_MASK, 32'h0);
		wait_cyc(2);
		chk(irq, 1'b0);
		apb(1'b1, `PSIO_OFS_IRQ_STAT, 32'h1);
		apb(1'b0, `PSIO_OFS_IRQ_STAT, 32'h0);
		chk(q[0], 1'b0);
		apb(1'b0, 12'h030, 32'h0);
		chk(err, 1'b1);
	endtask

	task automatic t_tx();
		logic [7:0] f;
		output_on <= 1'b0;
		protect_active <= 1'b0;
		wait_cyc(3);
		f = falls;
		output_on <= 1'b1;
		wait_cyc(3100);
		chk(falls - f, 8'h01);
		chk(low_len >= 16'd3000, 1'b1);
		output_on <= 1'b0;
		protect_active <= 1'b1;
		wait_cyc(3);
		output_on <= 1'b1;
		wait_cyc(50);
		chk(falls - f, 8'h01);
		protect_active <= 1'b0;
	endtask

	task automatic end_sim();
		$display("errors=%0d checks=%0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		wait_cyc(3);
		presetn <= 1'b1;
		t_levels();
		t_gpo();
		t_pwm();
		t_gpi();
		t_clear();
		t_tx();
		end_sim();
	end
endmodule
`default_nettype wire
